// File: shared/sgd_defs.svh
`ifndef SGD_DEFS_SVH
`define SGD_DEFS_SVH
// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define SGD_ADDR_CTRL 12'h000
`define SGD_ADDR_TIME 12'h004
`define SGD_ADDR_STAT 12'h008
`define SGD_ADDR_IEN 12'h00C
`define SGD_ADDR_ICLR 12'h010
`define SGD_ADDR_FLT 12'h014
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SGD_CTRL_CUR_LSB 0
`define SGD_CTRL_SERIAL_BIT 4
`define SGD_CTRL_LSREF_BIT 5
`define SGD_CTRL_FETSNS_BIT 6
`define SGD_CTRL_TRIP_LSB 8
`define SGD_CTRL_RESET 32'h0000_0010
// ----------------------------------------------------------------------------
// Timing register fields and resets (cycles of the 20 MHz clock)
// ----------------------------------------------------------------------------
`define SGD_TIME_DRIVE_LSB 0
`define SGD_TIME_DEAD_LSB 8
`define SGD_TIME_OCP_LSB 16
`define SGD_TIME_RESET 32'h0010_0220
// ----------------------------------------------------------------------------
// Fixed figures
// ----------------------------------------------------------------------------
`define SGD_CLK_MHZ 20
`define SGD_DISCHARGE_NS 200
`define SGD_DISCHARGE_CYC ((`SGD_DISCHARGE_NS * `SGD_CLK_MHZ) / 1000)
`define SGD_PIN_LEVELS 7
`define SGD_SPI_LEVELS 16
`define SGD_TRIP_MAX_SPI 8'hFF
`define SGD_TRIP_MAX_PIN 8'h7F
`define SGD_GLITCH_CYC 2
`endif

// File: shared/sgd_pkg.sv
package sgd_pkg;
  typedef enum logic [2:0] {
    SGD_IDLE  = 3'b000,
    SGD_DEAD  = 3'b001,
    SGD_EXTRA = 3'b011,
    SGD_DRIVE = 3'b010,
    SGD_HOLD  = 3'b110
  } sgd_state_t;
endpackage : sgd_pkg

// File: logic/sgd_gate_ctrl.sv
`timescale 1ns/1ps
`include "sgd_defs.svh"
// Function
// - Serial variant: sixteen current strengths
// - Pin variant: seven strengths from pin level
// - Drive current for drive time, then hold
// - Dead time from gate voltage monitors
// - Serial variant adds register extra dead time
// - High-to-low handshake may stretch 100-200 ns
// - Strong pulldown on opposite gate during drive
// - Monitor gate voltage on state change
// - Gate fault if threshold missed at end
// - Drive time ends early on new command
// - Deglitch every PWM input
// - Overcurrent only after deglitch time above trip
// - High vs phase, low phase vs source
// - Register picks low-side reference pin
// - Trip level range 0.06-2 V or 1 V
// - Amplifier FET sense forces shunt reference
module sgd_gate_ctrl
  import sgd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pin-variant strength level
  input wire logic [2:0] pin_current_level_i,
  // PWM commands, one bit per phase
  input wire logic [2:0] pwm_high_i,
  input wire logic [2:0] pwm_low_i,
  // Gate voltage monitors: high when the gate is above its on threshold
  input wire logic [2:0] vgs_high_on_i,
  input wire logic [2:0] vgs_low_on_i,
  // Drain-source comparators, already above the programmed trip level
  input wire logic [2:0] hs_drain_vs_phase_i,
  input wire logic [2:0] ls_phase_vs_source_i,
  input wire logic [2:0] ls_phase_vs_shunt_i,
  // Gate drive outputs
  output logic [2:0] gate_high_o,
  output logic [2:0] gate_low_o,
  output logic [2:0] drive_strong_o,
  output logic [2:0] pulldown_high_o,
  output logic [2:0] pulldown_low_o,
  output logic [3:0] gate_current_setting_o,
  output logic [7:0] drain_source_trip_level_o,
  output logic [2:0] ls_use_shunt_o,
  // Interrupt
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] time_reg, time_next;
  logic [5:0] ien_reg, ien_next;
  logic [5:0] stat_reg, stat_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [5:0] ev_set;
  logic wr_en, rd_en;
  logic ack_reg, ack_next;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  // Reads take one wait state so that prdata stands from a flop while pready is high
  assign pready_o = pwrite_i || ack_reg;
  assign prdata_o = prdata_reg;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `SGD_ADDR_CTRL) || (a == `SGD_ADDR_TIME) || (a == `SGD_ADDR_STAT) ||
                 (a == `SGD_ADDR_IEN) || (a == `SGD_ADDR_ICLR) || (a == `SGD_ADDR_FLT);
  endfunction : addr_known

  assign pslverr_o = psel_i && penable_i && !addr_known(paddr_i);

  logic serial_mode, low_side_reference_select_shunt, fet_sense;
  logic [7:0] drive_cyc, dead_cyc, ocp_cyc;
  assign serial_mode = ctrl_reg[`SGD_CTRL_SERIAL_BIT];
  assign low_side_reference_select_shunt = ctrl_reg[`SGD_CTRL_LSREF_BIT];
  assign fet_sense = ctrl_reg[`SGD_CTRL_FETSNS_BIT];
  assign drive_cyc = time_reg[`SGD_TIME_DRIVE_LSB +: 8];
  assign dead_cyc = serial_mode ? time_reg[`SGD_TIME_DEAD_LSB +: 8] : 8'h00;
  assign ocp_cyc = time_reg[`SGD_TIME_OCP_LSB +: 8];

  // Trip level code: 8'h00 maps to 0.06 V; pin variant caps at the 1 V code
  logic [7:0] trip_raw;
  assign trip_raw = ctrl_reg[`SGD_CTRL_TRIP_LSB +: 8];
  always_comb begin
    if (!serial_mode && trip_raw > `SGD_TRIP_MAX_PIN) begin
      drain_source_trip_level_o = `SGD_TRIP_MAX_PIN;
    end else begin
      drain_source_trip_level_o = trip_raw;
    end
  end

  // Sixteen codes in serial mode, seven pin levels otherwise
  always_comb begin
    if (serial_mode) begin
      gate_current_setting_o = ctrl_reg[`SGD_CTRL_CUR_LSB +: 4];
    end else if (pin_current_level_i >= 3'(`SGD_PIN_LEVELS)) begin
      gate_current_setting_o = 4'(`SGD_PIN_LEVELS - 1);
    end else begin
      gate_current_setting_o = {1'b0, pin_current_level_i};
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    time_next = time_reg;
    ien_next = ien_reg;
    prdata_next = prdata_reg;
    ack_next = rd_en && !ack_reg;
    stat_next = stat_reg;
    if (wr_en && paddr_i == `SGD_ADDR_ICLR) begin
      stat_next = stat_reg & ~pwdata_i[5:0];
    end
    stat_next = stat_next | ev_set; // Set wins over a same-cycle clear
    if (wr_en) begin
      case (paddr_i)
        `SGD_ADDR_CTRL: ctrl_next = {16'h0000, pwdata_i[15:8], 1'b0, pwdata_i[6:0]};
        `SGD_ADDR_TIME: time_next = {8'h00, pwdata_i[23:0]};
        `SGD_ADDR_IEN: ien_next = pwdata_i[5:0];
        default: ;
      endcase
    end
    if (rd_en && !ack_reg) begin
      case (paddr_i)
        `SGD_ADDR_CTRL: prdata_next = ctrl_reg;
        `SGD_ADDR_TIME: prdata_next = time_reg;
        `SGD_ADDR_STAT: prdata_next = {26'h0, stat_reg};
        `SGD_ADDR_IEN: prdata_next = {26'h0, ien_reg};
        `SGD_ADDR_FLT: prdata_next = {29'h0, ls_use_shunt_o};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SGD_CTRL_RESET;
      time_reg <= `SGD_TIME_RESET;
      ien_reg <= 6'h00;
      stat_reg <= 6'h00;
      prdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      time_reg <= time_next;
      ien_reg <= ien_next;
      stat_reg <= stat_next;
      prdata_reg <= prdata_next;
      ack_reg <= ack_next;
    end
  end

  assign irq_o = |(stat_reg & ien_reg);

  // --------------------------------------------------------------------------
  // Per-phase gate sequencer
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_phase
      // Input deglitch: a new level must hold for a few cycles
      logic [1:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
      logic hi_f_reg, hi_f_next, lo_f_reg, lo_f_next;
      logic [1:0] cmd_reg, cmd_next;
      sgd_state_t st_reg, st_next;
      logic [7:0] cnt_reg, cnt_next;
      logic [7:0] ocp_h_reg, ocp_h_next, ocp_l_reg, ocp_l_next;
      logic gh_reg, gh_next, gl_reg, gl_next;
      logic ev_gate, ev_oc;
      logic ls_trip, want_h, want_l, target_on;

      assign ls_use_shunt_o[g] = fet_sense | low_side_reference_select_shunt;
      assign ls_trip = ls_use_shunt_o[g] ? ls_phase_vs_shunt_i[g]
                                         : ls_phase_vs_source_i[g];
      assign want_h = cmd_reg[1] && !cmd_reg[0];
      assign want_l = cmd_reg[0] && !cmd_reg[1];
      // Monitor of the gate that was last commanded to switch
      assign target_on = gh_reg ? vgs_high_on_i[g] : gl_reg ? vgs_low_on_i[g] : 1'b0;

      always_comb begin
        hi_cnt_next = (pwm_high_i[g] == hi_f_reg) ? 2'd0 : hi_cnt_reg + 2'd1;
        lo_cnt_next = (pwm_low_i[g] == lo_f_reg) ? 2'd0 : lo_cnt_reg + 2'd1;
        hi_f_next = hi_f_reg;
        lo_f_next = lo_f_reg;
        if (hi_cnt_reg == 2'(`SGD_GLITCH_CYC)) begin
          hi_f_next = pwm_high_i[g];
          hi_cnt_next = 2'd0;
        end
        if (lo_cnt_reg == 2'(`SGD_GLITCH_CYC)) begin
          lo_f_next = pwm_low_i[g];
          lo_cnt_next = 2'd0;
        end
      end

      always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        gh_next = gh_reg;
        gl_next = gl_reg;
        ev_gate = 1'b0;
        cmd_next = {hi_f_reg, lo_f_reg};
        if (cmd_next != cmd_reg) begin
          // New command cuts any drive interval short
          gh_next = 1'b0;
          gl_next = 1'b0;
          st_next = SGD_DEAD;
          cnt_next = 8'h00;
        end else begin
          case (st_reg)
            SGD_IDLE: ;
            SGD_DEAD: begin
              // Wait for both gate monitors to read off, bounded by discharge time plus drive time
              if (!vgs_high_on_i[g] && !vgs_low_on_i[g]) begin
                st_next = SGD_EXTRA;
                cnt_next = 8'h00;
              end else if (cnt_reg == 8'(`SGD_DISCHARGE_CYC) + drive_cyc) begin
                ev_gate = 1'b1;
                st_next = SGD_EXTRA;
                cnt_next = 8'h00;
              end else begin
                cnt_next = cnt_reg + 8'h01;
              end
            end
            SGD_EXTRA: begin
              if (cnt_reg >= dead_cyc) begin
                gh_next = want_h;
                gl_next = want_l;
                st_next = (want_h || want_l) ? SGD_DRIVE : SGD_IDLE;
                cnt_next = 8'h00;
              end else begin
                cnt_next = cnt_reg + 8'h01;
              end
            end
            SGD_DRIVE: begin
              if (cnt_reg + 8'h01 >= drive_cyc) begin
                st_next = SGD_HOLD;
                ev_gate = !target_on;
              end else begin
                cnt_next = cnt_reg + 8'h01;
              end
            end
            SGD_HOLD: ;
            default: st_next = SGD_IDLE;
          endcase
        end
      end

      // Overcurrent only after the comparator stays high for the deglitch time
      always_comb begin
        ocp_h_next = (hs_drain_vs_phase_i[g] && gh_reg) ? ocp_h_reg + 8'h01 : 8'h00;
        ocp_l_next = (ls_trip && gl_reg) ? ocp_l_reg + 8'h01 : 8'h00;
        ev_oc = (ocp_h_reg > ocp_cyc) || (ocp_l_reg > ocp_cyc);
        if (ev_oc) begin
          ocp_h_next = 8'h00;
          ocp_l_next = 8'h00;
        end
      end

      assign ev_set[g] = ev_gate;
      assign ev_set[g + 3] = ev_oc;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hi_cnt_reg <= 2'd0;
          lo_cnt_reg <= 2'd0;
          hi_f_reg <= 1'b0;
          lo_f_reg <= 1'b0;
          cmd_reg <= 2'b00;
          st_reg <= SGD_IDLE;
          cnt_reg <= 8'h00;
          gh_reg <= 1'b0;
          gl_reg <= 1'b0;
          ocp_h_reg <= 8'h00;
          ocp_l_reg <= 8'h00;
        end else begin
          hi_cnt_reg <= hi_cnt_next;
          lo_cnt_reg <= lo_cnt_next;
          hi_f_reg <= hi_f_next;
          lo_f_reg <= lo_f_next;
          cmd_reg <= cmd_next;
          st_reg <= st_next;
          cnt_reg <= cnt_next;
          gh_reg <= gh_next;
          gl_reg <= gl_next;
          ocp_h_reg <= ocp_h_next;
          ocp_l_reg <= ocp_l_next;
        end
      end

      assign gate_high_o[g] = gh_reg;
      assign gate_low_o[g] = gl_reg;
      assign drive_strong_o[g] = (st_reg == SGD_DRIVE);
      // Opposite gate gets strong pulldown while the other switches
      assign pulldown_low_o[g] = (st_reg == SGD_DRIVE) && gh_reg;
      assign pulldown_high_o[g] = (st_reg == SGD_DRIVE) && gl_reg;
    end
  endgenerate

endmodule : sgd_gate_ctrl

// File: verif/sgd_gate_ctrl_assertions.sv
`timescale 1ns/1ps
module sgd_gate_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [2:0] pwm_high_i,
  input wire logic [2:0] vgs_low_on_i,
  input wire logic [2:0] gate_high_o,
  input wire logic [2:0] gate_low_o,
  input wire logic [2:0] drive_strong_o,
  input wire logic [2:0] pulldown_high_o,
  input wire logic [2:0] pulldown_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_NO_OVERLAP: assert property (!(gate_high_o[0] && gate_low_o[0]))
    else $error("both gates on");
  AST_DEAD_WAIT: assert property ($rose(gate_high_o[0]) |-> !$past(vgs_low_on_i[0]))
    else $error("high gate on before low gate off");
  AST_STRONG: assert property ($rose(gate_high_o[0]) |-> drive_strong_o[0])
    else $error("no strong drive on turn on");
  AST_PULLDOWN: assert property ($rose(gate_low_o[0]) |-> pulldown_high_o[0])
    else $error("no pulldown on opposite gate");
  AST_PULLDOWN_LOW: assert property ($rose(gate_high_o[0]) |-> pulldown_low_o[0])
    else $error("no pulldown on low gate");
  AST_PWM_OFF: assert property ((!pwm_high_i[0])[*8] |-> !gate_high_o[0])
    else $error("gate outlives command");
  AST_GLITCH: assert property ((!pwm_high_i[0] && !gate_high_o[0])[*4]
    ##1 pwm_high_i[0] ##1 !pwm_high_i[0] |=> (!gate_high_o[0])[*6])
    else $error("glitch reached gate");
  AST_READY: assert property (psel_i && penable_i |-> ##[0:1] pready_o)
    else $error("access not answered");
  AST_SLVERR: assert property (psel_i && penable_i && paddr_i == 12'h018 |-> pslverr_o)
    else $error("unmapped access not refused");
endmodule : sgd_gate_ctrl_assertions
bind sgd_gate_ctrl sgd_gate_ctrl_assertions sgd_gate_ctrl_assertions_i (.*);

// File: verif/sgd_fet_model.sv
`timescale 1ns/1ps
module sgd_fet_model (
  input wire logic clk_i,
  input wire logic [2:0] gh_i,
  input wire logic [2:0] gl_i,
  input wire logic [2:0] stuck_i,
  input wire logic slow_i,
  output logic [2:0] vh_o,
  output logic [2:0] vl_o
);
  logic [2:0] h1, h2, h3, l1;
  always_ff @(posedge clk_i) begin
    h1 <= gh_i;
    h2 <= h1;
    h3 <= h2;
    l1 <= gl_i;
  end
  // Slow discharge stays shorter than the drive time
  assign vh_o = (slow_i ? (h1 | h3) : h1) & ~stuck_i;
  assign vl_o = l1;
endmodule : sgd_fet_model

// File: verif/sgd_gate_ctrl_bench.sv
`timescale 1ns/1ps
`include "sgd_defs.svh"
module sgd_gate_ctrl_bench;
  import sgd_pkg::*;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, slow = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic pready_o, pslverr_o, irq_o;
  logic [2:0] pin_current_level_i = 0, pwm_high_i = 0, pwm_low_i = 0, stuck = 0;
  logic [2:0] hs_drain_vs_phase_i = 0, ls_phase_vs_source_i = 0, ls_phase_vs_shunt_i = 0;
  logic [2:0] vgs_high_on_i, vgs_low_on_i, gate_high_o, gate_low_o, drive_strong_o;
  logic [2:0] pulldown_high_o, pulldown_low_o, ls_use_shunt_o;
  logic [3:0] gate_current_setting_o, exp_cur;
  logic [7:0] drain_source_trip_level_o;
  logic [31:0] q[$];
  int err_total = 0, comparisons = 0, seed = 33931, i;
  always #25 clk_i = ~clk_i;
  sgd_gate_ctrl sgd_gate_ctrl_i (.*);
  sgd_fet_model sgd_fet_model_i (.clk_i(clk_i), .gh_i(gate_high_o), .gl_i(gate_low_o),
    .stuck_i(stuck), .slow_i(slow), .vh_o(vgs_high_on_i), .vl_o(vgs_low_on_i));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
  endtask : apb
  // Read data is taken at the edge where the access phase meets pready
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      chk("prdata", prdata_o, q.pop_front());
    end
  end
  task waitg(input logic [2:0] h, input logic [2:0] l);
    for (i = 0; i < 60 && (gate_high_o !== h || gate_low_o !== l); i++) @(posedge clk_i);
    chk("gates", {gate_high_o, gate_low_o}, {h, l});
    @(posedge clk_i);
  endtask : waitg
  task results;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    #2000000;
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    apb(0, `SGD_ADDR_CTRL, `SGD_CTRL_RESET);
    apb(0, `SGD_ADDR_TIME, `SGD_TIME_RESET);
    apb(0, 12'h018, 32'h0);
    apb(1, `SGD_ADDR_TIME, 32'h0003_0208);
    apb(1, `SGD_ADDR_IEN, 32'h3F);
    pwm_high_i <= 3'h1;
    waitg(3'h1, 3'h0);
    pwm_high_i <= 3'h0;
    pwm_low_i <= 3'h1;
    slow <= 1;
    waitg(3'h0, 3'h1);
    slow <= 0;
    pwm_high_i <= 3'h3;
    @(posedge clk_i);
    pwm_high_i <= 3'h0;
    repeat (10) @(posedge clk_i);
    chk("glitch", {gate_high_o, gate_low_o}, 6'h01);
    ls_phase_vs_source_i <= 3'h1;
    repeat (8) @(posedge clk_i);
    ls_phase_vs_source_i <= 3'h0;
    apb(0, `SGD_ADDR_STAT, 32'h8);
    apb(1, `SGD_ADDR_ICLR, 32'h8);
    ls_phase_vs_shunt_i <= 3'h1;
    repeat (8) @(posedge clk_i);
    ls_phase_vs_shunt_i <= 3'h0;
    apb(0, `SGD_ADDR_STAT, 32'h0);
    stuck <= 3'h2;
    pwm_high_i <= 3'h2;
    repeat (30) @(posedge clk_i);
    apb(0, `SGD_ADDR_STAT, 32'h2);
    chk("irq", irq_o, 1'b1);
    apb(1, `SGD_ADDR_IEN, 32'h0);
    chk("irq", irq_o, 1'b0);
    apb(1, `SGD_ADDR_ICLR, 32'h2);
    apb(0, `SGD_ADDR_STAT, 32'h0);
    stuck <= 3'h0;
    pwm_high_i <= 3'h1;
    pwm_low_i <= 3'h0;
    waitg(3'h1, 3'h0);
    pwm_high_i <= 3'h0;
    // Looked at before the drive interval would have run out by itself
    repeat (5) @(posedge clk_i);
    chk("strong", drive_strong_o, 3'h0);
    pwm_high_i <= 3'h1;
    waitg(3'h1, 3'h0);
    repeat (10) @(posedge clk_i);
    hs_drain_vs_phase_i <= 3'h1;
    repeat (2) @(posedge clk_i);
    hs_drain_vs_phase_i <= 3'h0;
    apb(0, `SGD_ADDR_STAT, 32'h0);
    hs_drain_vs_phase_i <= 3'h1;
    repeat (8) @(posedge clk_i);
    hs_drain_vs_phase_i <= 3'h0;
    apb(0, `SGD_ADDR_STAT, 32'h8);
    apb(1, `SGD_ADDR_ICLR, 32'h8);
    apb(1, `SGD_ADDR_CTRL, 32'h0000_FF3A);
    chk("cur", gate_current_setting_o, 4'hA);
    chk("trip", drain_source_trip_level_o, 8'hFF);
    apb(0, `SGD_ADDR_FLT, 32'h7);
    apb(1, `SGD_ADDR_CTRL, 32'h0000_0010);
    chk("ref", ls_use_shunt_o, 3'h0);
    apb(1, `SGD_ADDR_CTRL, 32'h0000_FF40);
    chk("trip", drain_source_trip_level_o, 8'h7F);
    chk("ref", ls_use_shunt_o, 3'h7);
    pin_current_level_i <= 3'h7;
    @(posedge clk_i);
    chk("cur", gate_current_setting_o, `SGD_PIN_LEVELS - 1);
    repeat (6) begin
      pin_current_level_i <= 3'($random(seed));
      @(posedge clk_i);
      exp_cur = (pin_current_level_i >= `SGD_PIN_LEVELS) ? 4'(`SGD_PIN_LEVELS - 1)
                                                         : {1'b0, pin_current_level_i};
      chk("cur", gate_current_setting_o, exp_cur);
    end
    results();
  end
endmodule : sgd_gate_ctrl_bench
